// >>> logic/eau_top.sv
// Effective address unit with its AHB-Lite control registers.
//
// Operation
// - Direct mode: register is the operand.
// - Indirect: register addresses memory, unchanged.
// - Displacement modes add one or two bytes.
// - Short displacements are sign extended.
// - Pre-decrement steps, writes back, addresses.
// - Post-increment addresses, then steps register.
// - Step one byte, two word, two stack.
// - Immediate operand from extension bytes.
// - Short absolute: zero page, base, byte.
// - Long absolute: data page, extension.
// - Branch adds displacement to PC, code page.
// - Base register picks the page.
// - Minimum mode ignores page registers.
// - Size bit: zero byte, one word.
// - Register select is binary.
// - Branch form flagged by opcode.
// - Maximum mode honours pages, minimum 64k.
// - Stack pointer auto modes access words.
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module eau_top
   import eau_pkg::*;
#(
   // Width of the result counter.
   parameter int COUNT_W = 16
) (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst,
   // AHB-Lite slave.
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // Decode requests from the fetch stage.
   input wire logic i_req_valid,
   input wire eau_req_s i_req,
   output logic o_req_ready,
   // Register file read and write ports.
   output logic [2:0] o_rf_rd_idx,
   input wire logic [15:0] i_rf_rd_data,
   output logic o_rf_wr_en,
   output logic [2:0] o_rf_wr_idx,
   output logic [15:0] o_rf_wr_data,
   // Results toward the memory access path.
   output logic o_res_valid,
   output eau_res_s o_res
);
   // The counter must fit the 32-bit data bus.
   if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_width
      $error("COUNT_W must lie between 1 and 32");
   end

   // Pipeline states: waiting for a request, or computing.
   typedef enum logic [1:0] {
      EAU_ST_IDLE = 2'b00,
      EAU_ST_CALC = 2'b01
   } eau_state_e;

   // Decode of a register offset into a read word.
   function automatic logic [31:0] rd_word(
      input logic [7:0] ofs,
      input logic max_mode,
      input eau_pages_s pages,
      input logic [7:0] base,
      input logic ill,
      input logic [23:0] last,
      input logic [COUNT_W-1:0] count
   );
      rd_word = 32'h0000_0000;
      case (ofs)
         EAU_OFS_CTRL: begin
            rd_word[EAU_CTRL_MAX_BIT] = max_mode;
         end
         EAU_OFS_PAGE: begin
            rd_word = pages;
         end
         EAU_OFS_BASE: begin
            rd_word[7:0] = base;
         end
         EAU_OFS_STAT: begin
            rd_word[23:0] = last;
            rd_word[EAU_STAT_ILL_BIT] = ill;
         end
         EAU_OFS_COUNT: begin
            rd_word[COUNT_W-1:0] = count;
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   endfunction

   // Bus state: pending write and its offset, read data.
   logic wr_pend_q;
   logic wr_pend_d;
   logic [7:0] wr_ofs_q;
   logic [7:0] wr_ofs_d;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;

   // Software visible control and status.
   logic max_mode_q;
   logic max_mode_d;
   eau_pages_s pages_q;
   eau_pages_s pages_d;
   logic [7:0] base_q;
   logic [7:0] base_d;
   logic ill_q;
   logic ill_d;
   logic [23:0] last_q;
   logic [23:0] last_d;
   logic [COUNT_W-1:0] count_q;
   logic [COUNT_W-1:0] count_d;

   // Pipeline state.
   eau_state_e state_q;
   eau_state_e state_d;
   eau_req_s req_q;
   eau_req_s req_d;
   logic [2:0] rd_idx_q;
   logic [2:0] rd_idx_d;
   logic res_valid_q;
   logic res_valid_d;
   eau_res_s res_q;
   eau_res_s res_d;
   logic wr_en_q;
   logic wr_en_d;
   logic [2:0] wr_idx_q;
   logic [2:0] wr_idx_d;
   logic [15:0] wr_data_q;
   logic [15:0] wr_data_d;

   // Combinational result of the arithmetic module.
   eau_res_s calc_res;
   logic calc_wb_en;
   logic [15:0] calc_wb_data;
   // Address phase of a valid transfer to this slave.
   logic bus_take;
   // A result is finished in this cycle.
   logic done;

   assign bus_take = i_hsel && i_hready && i_htrans[1];
   assign done = state_q == EAU_ST_CALC;

   // Arithmetic on the latched request and the register read.
   eau_addr_calc u_calc (
      .i_req(req_q),
      .i_rn(i_rf_rd_data),
      .i_pages(pages_q),
      .i_base(base_q),
      .i_max_mode(max_mode_q),
      .o_res(calc_res),
      .o_wb_en(calc_wb_en),
      .o_wb_data(calc_wb_data)
   );

   // Next values of the bus slave and the software registers.
   always_comb begin
      wr_pend_d = 1'b0;
      wr_ofs_d = wr_ofs_q;
      hrdata_d = hrdata_q;
      max_mode_d = max_mode_q;
      pages_d = pages_q;
      base_d = base_q;
      ill_d = ill_q;
      last_d = last_q;
      count_d = count_q;
      // A data phase write lands in the addressed register.
      if (wr_pend_q) begin
         case (wr_ofs_q)
            EAU_OFS_CTRL: begin
               max_mode_d = i_hwdata[EAU_CTRL_MAX_BIT];
            end
            EAU_OFS_PAGE: begin
               pages_d = i_hwdata;
            end
            EAU_OFS_BASE: begin
               base_d = i_hwdata[7:0];
            end
            EAU_OFS_STAT: begin
               // Writing one clears the sticky illegal flag.
               if (i_hwdata[EAU_STAT_ILL_BIT]) begin
                  ill_d = 1'b0;
               end
            end
            default: begin
               ill_d = ill_q;
            end
         endcase
      end
      // A finished result updates status; its set beats a clear.
      if (done) begin
         last_d = calc_res.addr;
         count_d = count_q + 1'b1;
         if (calc_res.illegal) begin
            ill_d = 1'b1;
         end
      end
      // An address phase is captured; reads are answered next cycle.
      if (bus_take) begin
         wr_pend_d = i_hwrite;
         wr_ofs_d = i_haddr[7:0];
         if (!i_hwrite) begin
            hrdata_d = rd_word(i_haddr[7:0], max_mode_q, pages_q, base_q,
                               ill_q, last_q, count_q);
         end
      end
   end

   // Registers of the bus slave and the software registers.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         wr_pend_q <= 1'b0;
         wr_ofs_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
         max_mode_q <= EAU_CTRL_RST;
         pages_q <= EAU_PAGE_RST;
         base_q <= EAU_BASE_RST;
         ill_q <= 1'b0;
         last_q <= 24'h00_0000;
         count_q <= '0;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_ofs_q <= wr_ofs_d;
         hrdata_q <= hrdata_d;
         max_mode_q <= max_mode_d;
         pages_q <= pages_d;
         base_q <= base_d;
         ill_q <= ill_d;
         last_q <= last_d;
         count_q <= count_d;
      end
   end

   // Next values of the decode pipeline.
   always_comb begin
      state_d = state_q;
      req_d = req_q;
      rd_idx_d = rd_idx_q;
      res_valid_d = 1'b0;
      res_d = res_q;
      wr_en_d = 1'b0;
      wr_idx_d = wr_idx_q;
      wr_data_d = wr_data_q;
      case (state_q)
         EAU_ST_IDLE: begin
            // Latch the request and point the register read at it.
            if (i_req_valid) begin
               req_d = i_req;
               rd_idx_d = i_req.effective_address_field[2:0];
               state_d = EAU_ST_CALC;
            end
         end
         EAU_ST_CALC: begin
            // Register data is present; publish the result.
            res_valid_d = 1'b1;
            res_d = calc_res;
            // Auto modes write the stepped value back.
            wr_en_d = calc_wb_en && !calc_res.illegal && !req_q.branch;
            wr_idx_d = rd_idx_q;
            wr_data_d = calc_wb_data;
            state_d = EAU_ST_IDLE;
         end
         default: begin
            state_d = EAU_ST_IDLE;
         end
      endcase
   end

   // Registers of the decode pipeline.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= EAU_ST_IDLE;
         req_q <= '0;
         rd_idx_q <= 3'h0;
         res_valid_q <= 1'b0;
         res_q <= '0;
         wr_en_q <= 1'b0;
         wr_idx_q <= 3'h0;
         wr_data_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         req_q <= req_d;
         rd_idx_q <= rd_idx_d;
         res_valid_q <= res_valid_d;
         res_q <= res_d;
         wr_en_q <= wr_en_d;
         wr_idx_q <= wr_idx_d;
         wr_data_q <= wr_data_d;
      end
   end

   // Ready flag held in a flop, true while idle, low in reset.
   logic ready_q;
   logic ready_d;

   // Ready drops the cycle a request is taken.
   always_comb begin
      ready_d = (state_d == EAU_ST_IDLE);
   end

   // Register of the ready flag.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= ready_d;
      end
   end

   // Bus answers are fixed: no wait states, always OKAY.
   logic hreadyout_q;
   logic hresp_q;

   // Registers of the fixed bus answer.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         hreadyout_q <= 1'b1;
         hresp_q <= EAU_HRESP_OKAY;
      end else begin
         hreadyout_q <= 1'b1;
         hresp_q <= EAU_HRESP_OKAY;
      end
   end

   // Outputs straight from flops.
   assign o_hrdata = hrdata_q;
   assign o_hreadyout = hreadyout_q;
   assign o_hresp = hresp_q;
   assign o_req_ready = ready_q;
   assign o_rf_rd_idx = rd_idx_q;
   assign o_rf_wr_en = wr_en_q;
   assign o_rf_wr_idx = wr_idx_q;
   assign o_rf_wr_data = wr_data_q;
   assign o_res_valid = res_valid_q;
   assign o_res = res_q;
endmodule

// >>> logic/eau_pkg.sv
// Constants, field layouts and carriers of the effective address unit.
package eau_pkg;
   // Upper nibble of the effective address field per mode.
   localparam logic [3:0] EAU_MODE_DIRECT = 4'hA;
   localparam logic [3:0] EAU_MODE_INDIRECT = 4'hD;
   localparam logic [3:0] EAU_MODE_DISP8 = 4'hE;
   localparam logic [3:0] EAU_MODE_DISP16 = 4'hF;
   localparam logic [3:0] EAU_MODE_PREDEC = 4'hB;
   localparam logic [3:0] EAU_MODE_POSTINC = 4'hC;
   localparam logic [3:0] EAU_MODE_ABS8 = 4'h0;
   localparam logic [3:0] EAU_MODE_ABS16 = 4'h1;
   // Whole field codes of the two immediate forms.
   localparam logic [7:0] EAU_FIELD_IMM8 = 8'h04;
   localparam logic [7:0] EAU_FIELD_IMM16 = 8'h0C;
   // Fixed low three bits of both absolute forms.
   localparam logic [2:0] EAU_ABS_LOW = 3'h5;
   // Position of the operand size bit in the field.
   localparam int EAU_SZ_BIT = 3;
   // Index of the stack pointer register.
   localparam logic [2:0] EAU_SP_IDX = 3'h7;
   // Auto step amounts.
   localparam logic [15:0] EAU_STEP_BYTE = 16'h0001;
   localparam logic [15:0] EAU_STEP_WORD = 16'h0002;
   // Upper address byte forced for short absolute and minimum mode.
   localparam logic [7:0] EAU_PAGE_ZERO = 8'h00;
   // Register byte offsets on the bus.
   localparam logic [7:0] EAU_OFS_CTRL = 8'h00;
   localparam logic [7:0] EAU_OFS_PAGE = 8'h04;
   localparam logic [7:0] EAU_OFS_BASE = 8'h08;
   localparam logic [7:0] EAU_OFS_STAT = 8'h0C;
   localparam logic [7:0] EAU_OFS_COUNT = 8'h10;
   // Field positions and reset values.
   localparam int EAU_CTRL_MAX_BIT = 0;
   localparam int EAU_STAT_ILL_BIT = 31;
   localparam logic EAU_CTRL_RST = 1'b0;
   localparam logic [31:0] EAU_PAGE_RST = 32'h0000_0000;
   localparam logic [7:0] EAU_BASE_RST = 8'h00;
   // Bus response codes.
   localparam logic EAU_HRESP_OKAY = 1'b0;

   // Page registers, laid out as the page register word.
   typedef struct packed {
      logic [7:0] code_page_register;
      logic [7:0] extended_page_register;
      logic [7:0] stack_page_register;
      logic [7:0] data_page_register;
   } eau_pages_s;

   // One decode request from the fetch stage.
   typedef struct packed {
      logic [7:0] effective_address_field;
      logic [15:0] ext;
      logic branch;
      logic disp_long;
      logic [15:0] pc;
   } eau_req_s;

   // One decode result toward the memory access path.
   typedef struct packed {
      logic illegal;
      logic use_mem;
      logic is_word;
      logic pc_load;
      logic [15:0] operand;
      logic [23:0] addr;
   } eau_res_s;
endpackage

// >>> logic/eau_addr_calc.sv
// Combinational effective address arithmetic for one request.
`timescale 1ns/1ps
module eau_addr_calc
   import eau_pkg::*;
(
   // Request and operands.
   input wire eau_req_s i_req,
   input wire logic [15:0] i_rn,
   input wire eau_pages_s i_pages,
   input wire logic [7:0] i_base,
   input wire logic i_max_mode,
   // Result and register write back.
   output eau_res_s o_res,
   output logic o_wb_en,
   output logic [15:0] o_wb_data
);
   // Sign extension shared by register and program counter forms.
   function automatic logic [15:0] sext8(input logic [7:0] v);
      sext8 = {{8{v[7]}}, v};
   endfunction

   logic [3:0] nib;
   logic [2:0] rsel;
   logic sz;
   logic [15:0] step;
   logic [15:0] sum;
   logic [7:0] page;

   // Forms the result of every mode from the sampled operands.
   always_comb begin
      nib = i_req.effective_address_field[7:4];
      sz = i_req.effective_address_field[EAU_SZ_BIT];
      rsel = i_req.effective_address_field[2:0];
      // Stack pointer always steps by a word.
      step = (sz || rsel == EAU_SP_IDX) ? EAU_STEP_WORD : EAU_STEP_BYTE;
      // Page follows the base register.
      if (rsel[2:1] == 2'b11) begin
         page = i_pages.stack_page_register;
      end else if (rsel[2]) begin
         page = i_pages.extended_page_register;
      end else begin
         page = i_pages.data_page_register;
      end
      if (!i_max_mode) begin
         page = EAU_PAGE_ZERO;
      end
      sum = 16'h0000;
      o_res = '0;
      o_res.is_word = sz;
      o_wb_en = 1'b0;
      o_wb_data = i_rn;
      if (i_req.branch) begin
         // Branch form carries no field of its own.
         sum = i_req.pc + (i_req.disp_long ? i_req.ext : sext8(i_req.ext[7:0]));
         o_res.pc_load = 1'b1;
         o_res.operand = sum;
         o_res.is_word = 1'b1;
         o_res.addr = {i_max_mode ? i_pages.code_page_register : EAU_PAGE_ZERO, sum};
      end else begin
         case (nib)
            EAU_MODE_DIRECT: begin
               o_res.operand = i_rn;
            end
            EAU_MODE_INDIRECT: begin
               o_res.use_mem = 1'b1;
               o_res.addr = {page, i_rn};
            end
            EAU_MODE_DISP8, EAU_MODE_DISP16: begin
               // The low nibble bit picks the two-byte displacement.
               sum = i_rn + (nib[0] ? i_req.ext : sext8(i_req.ext[7:0]));
               o_res.use_mem = 1'b1;
               o_res.addr = {page, sum};
            end
            EAU_MODE_PREDEC: begin
               sum = i_rn - step;
               o_wb_en = 1'b1;
               o_wb_data = sum;
               o_res.use_mem = 1'b1;
               o_res.is_word = step[1];
               o_res.addr = {page, sum};
            end
            EAU_MODE_POSTINC: begin
               o_wb_en = 1'b1;
               o_wb_data = i_rn + step;
               o_res.use_mem = 1'b1;
               o_res.is_word = step[1];
               o_res.addr = {page, i_rn};
            end
            EAU_MODE_ABS8, EAU_MODE_ABS16: begin
               if ({nib, sz, rsel} == EAU_FIELD_IMM8) begin
                  o_res.operand = {8'h00, i_req.ext[7:0]};
                  o_res.is_word = 1'b0;
               end else if ({nib, sz, rsel} == EAU_FIELD_IMM16) begin
                  o_res.operand = i_req.ext;
                  o_res.is_word = 1'b1;
               end else if (rsel != EAU_ABS_LOW) begin
                  o_res.illegal = 1'b1;
               end else if (nib == EAU_MODE_ABS8) begin
                  o_res.use_mem = 1'b1;
                  o_res.addr = {EAU_PAGE_ZERO, i_base, i_req.ext[7:0]};
               end else begin
                  o_res.use_mem = 1'b1;
                  o_res.addr = {i_max_mode ? i_pages.data_page_register : EAU_PAGE_ZERO,
                                i_req.ext};
               end
            end
            default: begin
               o_res.illegal = 1'b1;
            end
         endcase
      end
   end
endmodule

// >>> dv/eau_sva.sv
// Checker of the effective address unit's decode ports.
`timescale 1ns/1ps
module eau_chk
   import eau_pkg::*;
(
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst,
   // Decode request side.
   input wire logic i_req_valid,
   input wire eau_req_s i_req,
   input wire logic o_req_ready,
   // Register file side.
   input wire logic [2:0] o_rf_rd_idx,
   input wire logic [15:0] i_rf_rd_data,
   input wire logic o_rf_wr_en,
   input wire logic [15:0] o_rf_wr_data,
   // Result side.
   input wire logic o_res_valid,
   input wire eau_res_s o_res
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   // Field of the offered request and the taken strobes.
   logic [7:0] f;
   logic tk;
   logic bt;
   // Sign-extended short displacement, branch offset and auto step.
   logic [15:0] d8;
   logic [15:0] bd;
   logic [15:0] st;
   assign f = i_req.effective_address_field;
   assign tk = i_req_valid && o_req_ready && !i_req.branch;
   assign bt = i_req_valid && o_req_ready && i_req.branch;
   assign d8 = {{8{i_req.ext[7]}}, i_req.ext[7:0]};
   assign bd = i_req.disp_long ? i_req.ext : d8;
   assign st = (f[EAU_SZ_BIT] || f[2:0] == EAU_SP_IDX) ? EAU_STEP_WORD : EAU_STEP_BYTE;
   // A request of one mode is taken.
   sequence s_take(logic [3:0] m);
      tk && f[7:4] == m;
   endsequence
   // Its result lands two edges later.
   sequence s_res;
      ##2 o_res_valid;
   endsequence
   AST_DIRECT: assert property (s_take(EAU_MODE_DIRECT) |-> s_res ##0
      (!o_res.use_mem && o_res.operand == $past(i_rf_rd_data) && o_res.is_word == $past(f[3], 2)))
      else $error("direct wrong");
   AST_INDIRECT: assert property (s_take(EAU_MODE_INDIRECT) |-> s_res ##0
      (!o_rf_wr_en && o_res.addr[15:0] == $past(i_rf_rd_data)))
      else $error("indirect wrong");
   AST_DISP8: assert property (s_take(EAU_MODE_DISP8) |-> s_res ##0
      (o_res.addr[15:0] == $past(i_rf_rd_data) + $past(d8, 2)))
      else $error("disp8 wrong");
   AST_DISP16: assert property (s_take(EAU_MODE_DISP16) |-> s_res ##0
      (o_res.addr[15:0] == $past(i_rf_rd_data) + $past(i_req.ext, 2)))
      else $error("disp16 wrong");
   AST_PREDEC: assert property (s_take(EAU_MODE_PREDEC) |-> s_res ##0 (o_rf_wr_en
      && o_rf_wr_data == $past(i_rf_rd_data) - $past(st, 2) && o_res.addr[15:0] == o_rf_wr_data))
      else $error("predec wrong");
   AST_POSTINC: assert property (s_take(EAU_MODE_POSTINC) |-> s_res ##0 (o_rf_wr_en
      && o_res.addr[15:0] == $past(i_rf_rd_data) && o_rf_wr_data == $past(i_rf_rd_data) + $past(st, 2)))
      else $error("postinc wrong");
   AST_IMM8: assert property (tk && f == EAU_FIELD_IMM8 |-> s_res ##0
      (!o_res.use_mem && o_res.operand == {8'h00, $past(i_req.ext[7:0], 2)}))
      else $error("imm8 wrong");
   AST_ABS8: assert property (s_take(EAU_MODE_ABS8) ##0 f[2:0] == EAU_ABS_LOW |-> s_res ##0
      (o_res.addr[23:16] == EAU_PAGE_ZERO && o_res.addr[7:0] == $past(i_req.ext[7:0], 2)))
      else $error("abs8 wrong");
   AST_BRANCH: assert property (bt |-> ##2 o_res_valid && o_res.pc_load
      && o_res.addr[15:0] == $past(i_req.pc, 2) + $past(bd, 2))
      else $error("branch target wrong");
   AST_RD_IDX: assert property (tk && f[7] |=> !o_req_ready && o_rf_rd_idx == $past(f[2:0]))
      else $error("rd index wrong");
endmodule
bind eau_top eau_chk i_eau_chk (.*);

// >>> dv/eau_rf_model.sv
// Register file model behind the unit's read and write ports.
`timescale 1ns/1ps
module eau_rf_model (
   // Clock.
   input wire logic i_mclk,
   // Ports from the unit.
   input wire logic [2:0] i_rd_idx,
   output logic [15:0] o_rd_data,
   input wire logic i_wr_en,
   input wire logic [2:0] i_wr_idx,
   input wire logic [15:0] i_wr_data,
   // Preload port from the bench.
   input wire logic i_ld_en,
   input wire logic [2:0] i_ld_idx,
   input wire logic [15:0] i_ld_data
);
   // Eight general registers, unreset like real storage.
   logic [15:0] regs_q [8];
   // Reads answer in the same cycle, as the unit expects.
   assign o_rd_data = regs_q[i_rd_idx];
   // Write back from the unit wins over a preload.
   always_ff @(posedge i_mclk) begin
      if (i_wr_en) begin
         regs_q[i_wr_idx] <= i_wr_data;
      end else if (i_ld_en) begin
         regs_q[i_ld_idx] <= i_ld_data;
      end
   end
endmodule

// >>> dv/effective_address_unit_test.sv
// Self-checking bench of the effective address unit.
`timescale 1ns/1ps
module effective_address_unit_test
   import eau_pkg::*;
;
   // Design ports and bench state.
   logic i_mclk = 1'b0, i_rst = 1'b1, i_hsel = 1'b0, i_hwrite = 1'b0, i_req_valid = 1'b0;
   logic [1:0] i_htrans = 2'h0;
   logic [2:0] i_hsize = 3'h2;
   logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata;
   logic i_hready, o_hreadyout, o_hresp, o_req_ready, o_rf_wr_en, o_res_valid;
   eau_req_s i_req = '0;
   eau_res_s o_res;
   logic [2:0] o_rf_rd_idx, o_rf_wr_idx, ld_idx = 3'h0;
   logic [15:0] i_rf_rd_data, o_rf_wr_data, ld_data = 16'h0, n_res = 16'h0;
   logic ld_en = 1'b0, mx = 1'b0;
   logic [15:0] mirror [8];
   logic [7:0] bs = 8'h0;
   eau_pages_s pg = '0;
   int errors = 0, total_checks = 0, cyc = 0;
   // The one slave's ready is the bus ready.
   assign i_hready = o_hreadyout;
   always #2 i_mclk = ~i_mclk;
   eau_top i_eau_top (.*);
   eau_rf_model i_eau_rf_model (.i_mclk, .i_rd_idx(o_rf_rd_idx), .o_rd_data(i_rf_rd_data),
      .i_wr_en(o_rf_wr_en), .i_wr_idx(o_rf_wr_idx), .i_wr_data(o_rf_wr_data), .i_ld_en(ld_en),
      .i_ld_idx(ld_idx), .i_ld_data(ld_data));
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Cuts a hung run short.
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         errors++;
         stop_test();
      end
   end
   // Compares one bus or port word.
   task automatic chk_word(input logic [31:0] got, input logic [31:0] x);
      total_checks++;
      if (got !== x) begin
         errors++;
         $display("CHECK FAILED %0t word %h expected %h", $time, got, x);
      end
   endtask
   // Compares the defined bits of a result.
   task automatic chk_res(input eau_res_s got, input eau_res_s x, input eau_res_s k);
      total_checks++;
      if ((got & k) !== (x & k)) begin
         errors++;
         $display("CHECK FAILED %0t result %h expected %h", $time, got, x);
      end
   endtask
   // One AHB-Lite word transfer.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd);
      i_hsel <= 1'b1;
      i_htrans <= 2'h2;
      i_haddr <= {24'h0, a};
      i_hwrite <= w;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      i_htrans <= 2'h0;
      i_hwdata <= d;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      rd = o_hrdata;
      chk_word({31'h0, o_hresp}, 32'h0);
   endtask
   // Reads one register and compares it.
   task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0, rd);
      chk_word(rd, x);
   endtask
   // Loads a general register in the model and the mirror.
   task automatic load(input logic [2:0] n, input logic [15:0] v);
      ld_en <= 1'b1;
      ld_idx <= n;
      ld_data <= v;
      mirror[n] = v;
      @(posedge i_mclk);
      ld_en <= 1'b0;
      @(posedge i_mclk);
   endtask
   // Works out the result, its defined bits and the write back.
   function automatic void calc(input eau_req_s r, output eau_res_s e, output eau_res_s k,
      output logic wb, output logic [15:0] wd);
      logic [7:0] f, pa;
      logic [15:0] rn, a;
      f = r.effective_address_field;
      rn = mirror[f[2:0]];
      pa = f[2:1] == 2'h3 ? pg.stack_page_register : f[2] ? pg.extended_page_register
         : pg.data_page_register;
      a = rn;
      e = {2'h1, f[3], 41'h0};
      k = {4'hF, 16'h0, 24'hFF_FFFF};
      wb = 1'b0;
      wd = rn + ((f[3] || f[2:0] == 3'h7) ? 16'h2 : 16'h1);
      if (r.branch) begin
         a = r.pc + (r.disp_long ? r.ext : {{8{r.ext[7]}}, r.ext[7:0]});
         e = {4'h3, a, 24'h0};
         pa = pg.code_page_register;
         k = {4'hB, 16'hFFFF, 24'hFF_FFFF};
      end else begin
         case (f[7:4])
            EAU_MODE_DIRECT: begin
               e = {2'h0, f[3], 1'h0, rn, 24'h0};
               k = {4'hF, 16'hFFFF, 24'h0};
            end
            EAU_MODE_INDIRECT: a = rn;
            EAU_MODE_DISP8: a = rn + {{8{r.ext[7]}}, r.ext[7:0]};
            EAU_MODE_DISP16: a = rn + r.ext;
            EAU_MODE_PREDEC, EAU_MODE_POSTINC: begin
               if (f[4]) begin
                  wd = rn - (wd - rn);
                  a = wd;
               end
               wb = 1'b1;
               e.is_word = f[3] || f[2:0] == 3'h7;
            end
            default: begin
               if (f == EAU_FIELD_IMM8 || f == EAU_FIELD_IMM16) begin
                  e = {2'h0, f[3], 1'h0, f[3] ? r.ext : {8'h00, r.ext[7:0]}, 24'h0};
                  k = {4'hF, 16'hFFFF, 24'h0};
               end else if (f[7:5] == 3'h0 && f[2:0] == EAU_ABS_LOW) begin
                  a = f[4] ? r.ext : {bs, r.ext[7:0]};
                  pa = f[4] ? pg.data_page_register : EAU_PAGE_ZERO;
               end else begin
                  e = {4'h8, 40'h0};
                  k = {4'h8, 40'h0};
               end
            end
         endcase
      end
      e.addr = {mx ? pa : EAU_PAGE_ZERO, a};
   endfunction
   // Offers one request and checks its result.
   task automatic run_req(input eau_req_s r);
      eau_res_s e, k;
      logic wb;
      logic [15:0] wd;
      calc(r, e, k, wb, wd);
      i_req_valid <= 1'b1;
      i_req <= r;
      do @(posedge i_mclk); while (o_req_ready !== 1'b1);
      i_req_valid <= 1'b0;
      @(posedge i_mclk);
      #1;
      n_res++;
      chk_word({31'h0, o_res_valid}, 32'h1);
      chk_res(o_res, e, k);
      chk_word({12'h0, o_rf_wr_en, wb ? {o_rf_wr_idx, o_rf_wr_data} : 19'h0},
         {12'h0, wb, wb ? {r.effective_address_field[2:0], wd} : 19'h0});
      if (wb) mirror[r.effective_address_field[2:0]] = wd;
      @(posedge i_mclk);
   endtask
   // Main sequence.
   initial begin
      logic [31:0] rd;
      eau_req_s r;
      logic [7:0] f;
      void'($urandom(32'hB93D));
      repeat (8) @(posedge i_mclk);
      i_rst <= 1'b0;
      @(posedge i_mclk);
      for (int a = 0; a < 24; a += 4) rdchk(8'(a), 32'h0);
      $display("test reset values done");
      pg = eau_pages_s'($urandom);
      bs = 8'($urandom);
      bus(1'b1, EAU_OFS_PAGE, pg, rd);
      bus(1'b1, EAU_OFS_BASE, {24'h0, bs}, rd);
      rdchk(EAU_OFS_PAGE, pg);
      rdchk(EAU_OFS_BASE, {24'h0, bs});
      $display("test register access done");
      for (int p = 0; p < 2; p++) begin
         mx = p[0];
         bus(1'b1, EAU_OFS_CTRL, {31'h0, mx}, rd);
         for (int n = 0; n < 8; n++) load(3'(n), 16'($urandom));
         repeat (90) begin
            r.ext = 16'($urandom);
            r.pc = 16'($urandom);
            r.disp_long = 1'($urandom);
            r.branch = ($urandom % 6) == 0;
            // Mode nibbles A to F, then 0 and 1.
            f = {4'(($urandom % 8) + 10), 4'($urandom)};
            if (f[7:5] == 3'h0)
               f[2:0] = f[1] ? EAU_ABS_LOW : 3'h4;
            r.effective_address_field = f;
            run_req(r);
         end
         $display("test random decode done");
      end
      r = '0;
      load(3'h7, 16'h0001);
      r.effective_address_field = 8'hB7;
      run_req(r);
      load(3'h2, 16'hFFFF);
      r.effective_address_field = 8'hCA;
      run_req(r);
      r.effective_address_field = 8'hE1;
      r.ext = 16'h0080;
      run_req(r);
      r.effective_address_field = 8'h20;
      run_req(r);
      rdchk(EAU_OFS_STAT, 32'h8000_0000);
      bus(1'b1, EAU_OFS_STAT, 32'h8000_0000, rd);
      rdchk(EAU_OFS_STAT, 32'h0);
      rdchk(EAU_OFS_COUNT, {16'h0, n_res});
      $display("test corner cases done");
      stop_test();
   end
endmodule
